// >>> core/adc_cfg_pkg.sv
// constants shared by the adc output configuration register bank
package adc_cfg_pkg;
  // register slots held by the bank
  localparam int NUM_SLOTS = 17;
  localparam int ADDR_W = 10;
  localparam int IDX_W = 8;
  localparam int DATA_W = 8;
  localparam int BUS_W = 32;
  localparam int BE_W = 4;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SOFT_RESET = 8'h00;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam logic [7:0] IDX_CHA_TEST_SEL = 8'h25;
  localparam logic [7:0] IDX_CHB_TEST_SEL = 8'h2B;
  localparam logic [7:0] IDX_CHB_FILTER_SEL = 8'h2D;
  localparam logic [7:0] IDX_CHB_NS_ENABLE = 8'h2E;
  localparam logic [7:0] IDX_DC_LOOP_CTRL = 8'h3D;
  localparam logic [7:0] IDX_TEST_UPPER = 8'h3F;
  localparam logic [7:0] IDX_TEST_LOWER = 8'h40;
  localparam logic [7:0] IDX_OUT_IF_CFG = 8'h41;
  localparam logic [7:0] IDX_DIG_OPT_ONE = 8'h42;
  localparam logic [7:0] IDX_DIG_OPT_TWO = 8'h44;
  localparam logic [7:0] IDX_POWER_DRIVE = 8'h45;
  localparam logic [7:0] IDX_CHB_HIGH_FREQ = 8'h4A;
  localparam logic [7:0] IDX_CHA_HIGH_FREQ = 8'h58;
  localparam logic [7:0] IDX_CHA_PEDESTAL = 8'hBF;
  localparam logic [7:0] IDX_CHB_PEDESTAL = 8'hC1;
  localparam logic [7:0] IDX_LOOP_HOLD = 8'hCF;

  // slot numbers
  localparam int S_CTRL = 0;
  localparam int S_CHA_TEST = 1;
  localparam int S_CHB_TEST = 2;
  localparam int S_CHB_FILT = 3;
  localparam int S_CHB_NS = 4;
  localparam int S_DC_LOOP = 5;
  localparam int S_UPPER = 6;
  localparam int S_LOWER = 7;
  localparam int S_OUT_IF = 8;
  localparam int S_DIG1 = 9;
  localparam int S_DIG2 = 10;
  localparam int S_POWER = 11;
  localparam int S_CHB_HF = 12;
  localparam int S_CHA_HF = 13;
  localparam int S_CHA_PED = 14;
  localparam int S_CHB_PED = 15;
  localparam int S_HOLD = 16;

  localparam logic [7:0] SLOT_INDEX [NUM_SLOTS] = '{
    IDX_SOFT_RESET, IDX_CHA_TEST_SEL, IDX_CHB_TEST_SEL, IDX_CHB_FILTER_SEL,
    IDX_CHB_NS_ENABLE, IDX_DC_LOOP_CTRL, IDX_TEST_UPPER, IDX_TEST_LOWER,
    IDX_OUT_IF_CFG, IDX_DIG_OPT_ONE, IDX_DIG_OPT_TWO, IDX_POWER_DRIVE,
    IDX_CHB_HIGH_FREQ, IDX_CHA_HIGH_FREQ, IDX_CHA_PEDESTAL, IDX_CHB_PEDESTAL,
    IDX_LOOP_HOLD};
  // writable bits per slot; every other bit stores and reads zero
  localparam logic [7:0] SLOT_MASK [NUM_SLOTS] = '{
    8'h02, 8'h07, 8'h07, 8'h7F, 8'h40, 8'h20, 8'h3F, 8'hF8,
    8'hF0, 8'h08, 8'h01, 8'hE4, 8'h01, 8'h01, 8'hE0, 8'hE0, 8'h80};
  localparam logic [7:0] REG_RESET = 8'h00;

  // field positions
  localparam int BIT_SOFT_RESET = 1;
  localparam int BIT_NS_ON = 6;
  localparam int BIT_DC_LOOP_ON = 5;
  localparam int BIT_HOLD = 7;
  localparam int BIT_DIG1 = 3;
  localparam int BIT_DIG2 = 0;
  localparam int BIT_STANDBY_ALL_CHANNELS = 7;
  localparam int BIT_DIFF_CLK = 6;
  localparam int BIT_DIFF_DATA = 5;
  localparam int BIT_PDN = 2;
  localparam int BIT_HF = 0;
  localparam int FILT_HI = 6;
  localparam int IF_HI = 7;
  localparam int IF_LO = 6;
  localparam int DRV_HI = 5;
  localparam int DRV_LO = 4;
  localparam int UP_HI = 5;
  localparam int LOW_HI = 7;
  localparam int LOW_LO = 3;
  localparam int PED_HI = 7;
  localparam int PED_LO = 5;
  localparam int TEST_HI = 2;
  localparam int ST_READY = 0;
  localparam int ST_WAKING = 1;
  localparam logic [1:0] IF_DDR_DIFF = 2'b00;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int STANDBY_ALL_CHANNELS_WAKE_US = 50;
  localparam int PDN_WAKE_US = 100;
  localparam int NS_PER_US = 1000;
  localparam int STANDBY_ALL_CHANNELS_WAKE_CYCLES = STANDBY_ALL_CHANNELS_WAKE_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int PDN_WAKE_CYCLES = PDN_WAKE_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int WAKE_W = 14;

  // datapath
  localparam int SAMPLE_W = 11;
  localparam logic [10:0] MIDCODE = 11'h400;
  localparam logic [10:0] CODE_MAX = 11'h7FF;
  localparam logic [10:0] TOGGLE_A = 11'h555;
  localparam logic [10:0] TOGGLE_B = 11'h2AA;
  localparam int EST_FRAC = 4;
  localparam int EST_W = 16;
  localparam logic [2:0] RAMP_LAST = 3'h7;
  localparam logic [2:0] PED_PLUS4 = 3'b100;
  localparam logic signed [3:0] PED_FOUR = 4'sh4;

  typedef enum logic [2:0] {
    TP_NORMAL = 3'b000,
    TP_ZEROS = 3'b001,
    TP_ONES = 3'b010,
    TP_TOGGLE = 3'b011,
    TP_RAMP = 3'b100,
    TP_CUSTOM = 3'b101
  } test_sel_e;
endpackage

// >>> core/adc_channel_out.sv
// one channel output stage: offset loop, pedestal and test patterns
`timescale 1ns/1ps
module adc_channel_out (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // converter sample and settings
  input wire logic [10:0] sample_i,
  input wire logic [2:0] test_sel_i,
  input wire logic [10:0] custom_i,
  input wire logic corr_on_i,
  input wire logic hold_i,
  input wire logic [2:0] ped_i,
  input wire logic active_i,
  // output word
  output logic [10:0] data_o
);
  logic signed [15:0] est_reg;
  logic [2:0] ramp_div_reg;
  logic [10:0] ramp_reg;
  logic toggle_reg;
  logic [10:0] data_reg;
  logic signed [12:0] err;
  logic signed [13:0] corr_val;
  logic signed [3:0] ped_val;
  logic [10:0] normal_val;

  // pedestal code to signed lsb count
  always_comb begin
    if (ped_i == adc_cfg_pkg::PED_PLUS4) begin // [R14]
      ped_val = adc_cfg_pkg::PED_FOUR;
    end else begin
      ped_val = signed'({ped_i[2], ped_i});
    end
  end

  assign err = signed'({2'b00, sample_i}) -
    signed'({2'b00, adc_cfg_pkg::MIDCODE});

  // leaky estimate of the offset from midcode, frozen on hold
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      est_reg <= '0;
    end else if (!corr_on_i) begin // [R3]
      est_reg <= '0;
    end else if (!hold_i) begin // [R21]
      est_reg <= est_reg + 16'(err) - (est_reg >>> adc_cfg_pkg::EST_FRAC);
    end
  end

  // output driven to midcode plus pedestal, clamped to code range
  always_comb begin
    corr_val = signed'({3'b000, sample_i}) -
      14'(est_reg >>> adc_cfg_pkg::EST_FRAC) + 14'(ped_val); // [R15]
    if (!corr_on_i) begin
      normal_val = sample_i;
    end else if (corr_val < 0) begin
      normal_val = '0;
    end else if (corr_val > signed'({3'b000, adc_cfg_pkg::CODE_MAX})) begin
      normal_val = adc_cfg_pkg::CODE_MAX;
    end else begin
      normal_val = corr_val[10:0];
    end
  end

  // ramp steps every eighth clock, toggle flips every clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ramp_div_reg <= '0;
      ramp_reg <= '0;
      toggle_reg <= 1'b0;
    end else begin
      ramp_div_reg <= ramp_div_reg + 3'h1;
      toggle_reg <= ~toggle_reg;
      if (ramp_div_reg == adc_cfg_pkg::RAMP_LAST) begin
        ramp_reg <= ramp_reg + 11'h001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_reg <= '0;
    end else if (!active_i) begin
      data_reg <= '0;
    end else begin
      case (test_sel_i)
        adc_cfg_pkg::TP_NORMAL: data_reg <= normal_val;
        adc_cfg_pkg::TP_ZEROS: data_reg <= '0;
        adc_cfg_pkg::TP_ONES: data_reg <= adc_cfg_pkg::CODE_MAX;
        adc_cfg_pkg::TP_TOGGLE: data_reg <= toggle_reg ?
          adc_cfg_pkg::TOGGLE_B : adc_cfg_pkg::TOGGLE_A;
        adc_cfg_pkg::TP_RAMP: data_reg <= ramp_reg;
        adc_cfg_pkg::TP_CUSTOM: data_reg <= custom_i; // [R19]
        default: data_reg <= '0;
      endcase
    end
  end

  assign data_o = data_reg;

  sequence s_custom_sel;
    active_i && test_sel_i == adc_cfg_pkg::TP_CUSTOM;
  endsequence

  property p_custom_out;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_custom_sel |=> data_o == $past(custom_i);
  endproperty
  a_custom_out: assert property (p_custom_out) // [R19]
    else $error("custom pattern not presented");

  property p_hold_est;
    @(posedge clk_i) disable iff (!rst_n_i)
    (corr_on_i && hold_i) |=> est_reg == $past(est_reg);
  endproperty
  a_hold_est: assert property (p_hold_est) // [R21]
    else $error("held offset estimate moved");

  property p_loop_off;
    @(posedge clk_i) disable iff (!rst_n_i)
    (!corr_on_i && active_i && test_sel_i == adc_cfg_pkg::TP_NORMAL)
      |=> est_reg == 0 && data_o == $past(sample_i);
  endproperty
  a_loop_off: assert property (p_loop_off) // [R3]
    else $error("offset loop acted while disabled");

  property p_pedestal;
    @(posedge clk_i) disable iff (!rst_n_i)
    (corr_on_i && est_reg == 0 && active_i && sample_i == adc_cfg_pkg::MIDCODE
      && test_sel_i == adc_cfg_pkg::TP_NORMAL)
      |=> data_o == 11'($past(signed'({3'b000, sample_i}) + 14'(ped_val)));
  endproperty
  a_pedestal: assert property (p_pedestal) // [R14]
    else $error("pedestal not added to midcode");
endmodule // adc_channel_out

// >>> core/adc_output_config_regs.sv
// output configuration register bank of a dual-channel 11-bit converter
// Function
// R1 - channel B filter index, effective in digital mode
// R2 - channel B noise shaping on/off bit
// R3 - offset correction loop enable bit
// R4 - upper register gives pattern bits 10..5
// R5 - lower register gives pattern bits 4..0
// R6 - interface field 00 differential, else parallel
// R7 - parallel clock drive strength, four levels
// R8 - standby both channels, 50 us wake
// R9 - full power down, 100 us wake
// R10 - differential clock buffer double strength
// R11 - differential data buffers double strength
// R12 - channel B high input frequency mode
// R13 - channel A high input frequency mode
// R14 - pedestal code maps -3..+4 lsb
// R15 - loop drives midcode then adds pedestal
// R16 - each channel owns its pedestal register
// R17 - software writes zero to undefined bits
// R18 - every register reads zero after reset; the status register reads 01 in the code, as the converter is ready
// R19 - pattern code 101 outputs custom word
// R20 - soft reset clears all, self-clears
// R21 - freeze holds last offset estimate
// R22 - custom word is upper above lower
`timescale 1ns/1ps
module adc_output_config_regs #(
  parameter int STANDBY_ALL_CHANNELS_WAKE_CYCLES = adc_cfg_pkg::STANDBY_ALL_CHANNELS_WAKE_CYCLES,
  parameter int PDN_WAKE_CYCLES = adc_cfg_pkg::PDN_WAKE_CYCLES
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // avalon-mm slave
  input wire logic [9:0] ADDRESS_I,
  input wire logic READ_I,
  input wire logic WRITE_I,
  input wire logic [3:0] BYTEENABLE_I,
  input wire logic [31:0] WRITEDATA_I,
  output logic [31:0] READDATA_O,
  output logic WAITREQUEST_O,
  // converter samples
  input wire logic [10:0] CHA_SAMPLE_I,
  input wire logic [10:0] CHB_SAMPLE_I,
  // output words
  output logic [10:0] CHA_DATA_O,
  output logic [10:0] CHB_DATA_O,
  // noise shaping controls
  output logic [6:0] CHB_NOISE_FILTER_INDEX_O,
  output logic CHB_NOISE_SHAPING_ON_O,
  // output interface controls
  output logic OUTPUT_PARALLEL_O,
  output logic [1:0] PARALLEL_CLOCK_DRIVE_O,
  output logic DIFF_CLOCK_DRIVE_DOUBLE_O,
  output logic DIFF_DATA_DRIVE_DOUBLE_O,
  // power and frequency mode
  output logic STANDBY_ALL_CHANNELS_O,
  output logic FULL_POWER_DOWN_O,
  output logic CONVERTER_READY_O,
  output logic CHA_HIGH_INPUT_FREQ_ON_O,
  output logic CHB_HIGH_INPUT_FREQ_ON_O
);
  logic [7:0] regs [adc_cfg_pkg::NUM_SLOTS];
  logic [adc_cfg_pkg::NUM_SLOTS-1:0] hit;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wr_en;
  logic soft_reset;
  logic standby_all_channels_prev_reg;
  logic pdn_prev_reg;
  logic [13:0] wake_cnt_reg;
  logic [7:0] status_byte;
  logic digital_mode;
  logic [10:0] custom_word;
  logic active;
  logic chb_filt_on;

  // bus handshake: one wait cycle per access, then one gap cycle
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (READ_I | WRITE_I) & ~ack_reg;
    end
  end

  assign WAITREQUEST_O = ~ack_reg;
  assign wr_en = WRITE_I & ack_reg & BYTEENABLE_I[0];
  assign soft_reset = regs[adc_cfg_pkg::S_CTRL][adc_cfg_pkg::BIT_SOFT_RESET];

  // register slots, reserved bits stored as zero
  generate
    for (genvar s = 0; s < adc_cfg_pkg::NUM_SLOTS; s++) begin : g_slot
      assign hit[s] = ADDRESS_I[9:2] == adc_cfg_pkg::SLOT_INDEX[s];
      always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          regs[s] <= adc_cfg_pkg::REG_RESET; // [R18]
        end else if (soft_reset) begin
          regs[s] <= adc_cfg_pkg::REG_RESET; // [R20]
        end else if (wr_en && hit[s]) begin
          regs[s] <= WRITEDATA_I[7:0] & adc_cfg_pkg::SLOT_MASK[s]; // [R17]
        end
      end
    end
  endgenerate

  assign status_byte = {6'h00, wake_cnt_reg != '0, CONVERTER_READY_O};

  // read mux; unmapped indices read zero
  always_comb begin
    rdata_next = '0;
    for (int s = 0; s < adc_cfg_pkg::NUM_SLOTS; s++) begin
      if (hit[s]) begin
        rdata_next = {24'h000000, regs[s]};
      end
    end
    if (ADDRESS_I[9:2] == adc_cfg_pkg::IDX_STATUS) begin
      rdata_next = {24'h000000, status_byte};
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_reg <= '0;
    end else if (READ_I && !ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  assign READDATA_O = rdata_reg;

  // wake timing after standby or power down is released
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      standby_all_channels_prev_reg <= 1'b0;
      pdn_prev_reg <= 1'b0;
      wake_cnt_reg <= '0;
    end else begin
      standby_all_channels_prev_reg <= STANDBY_ALL_CHANNELS_O;
      pdn_prev_reg <= FULL_POWER_DOWN_O;
      if (FULL_POWER_DOWN_O || STANDBY_ALL_CHANNELS_O) begin
        wake_cnt_reg <= '0;
      end else if (pdn_prev_reg) begin
        wake_cnt_reg <= 14'(PDN_WAKE_CYCLES); // [R9]
      end else if (standby_all_channels_prev_reg) begin
        wake_cnt_reg <= 14'(STANDBY_ALL_CHANNELS_WAKE_CYCLES); // [R8]
      end else if (wake_cnt_reg != '0) begin
        wake_cnt_reg <= wake_cnt_reg - 14'h0001;
      end
    end
  end

  assign active = ~STANDBY_ALL_CHANNELS_O & ~FULL_POWER_DOWN_O &
    ~standby_all_channels_prev_reg & ~pdn_prev_reg & (wake_cnt_reg == '0);
  assign CONVERTER_READY_O = active;

  // configuration outputs
  assign digital_mode = regs[adc_cfg_pkg::S_DIG1][adc_cfg_pkg::BIT_DIG1];
  assign chb_filt_on = digital_mode;
  assign CHB_NOISE_FILTER_INDEX_O = chb_filt_on ?
    regs[adc_cfg_pkg::S_CHB_FILT][adc_cfg_pkg::FILT_HI:0] : 7'h00; // [R1]
  assign CHB_NOISE_SHAPING_ON_O =
    regs[adc_cfg_pkg::S_CHB_NS][adc_cfg_pkg::BIT_NS_ON]; // [R2]
  assign OUTPUT_PARALLEL_O =
    regs[adc_cfg_pkg::S_OUT_IF][adc_cfg_pkg::IF_HI:adc_cfg_pkg::IF_LO]
    != adc_cfg_pkg::IF_DDR_DIFF; // [R6]
  assign PARALLEL_CLOCK_DRIVE_O =
    regs[adc_cfg_pkg::S_OUT_IF]
      [adc_cfg_pkg::DRV_HI:adc_cfg_pkg::DRV_LO]; // [R7]
  assign DIFF_CLOCK_DRIVE_DOUBLE_O =
    regs[adc_cfg_pkg::S_POWER][adc_cfg_pkg::BIT_DIFF_CLK]; // [R10]
  assign DIFF_DATA_DRIVE_DOUBLE_O =
    regs[adc_cfg_pkg::S_POWER][adc_cfg_pkg::BIT_DIFF_DATA]; // [R11]
  assign STANDBY_ALL_CHANNELS_O =
    regs[adc_cfg_pkg::S_POWER][adc_cfg_pkg::BIT_STANDBY_ALL_CHANNELS]; // [R8]
  assign FULL_POWER_DOWN_O =
    regs[adc_cfg_pkg::S_POWER][adc_cfg_pkg::BIT_PDN]; // [R9]
  assign CHB_HIGH_INPUT_FREQ_ON_O =
    regs[adc_cfg_pkg::S_CHB_HF][adc_cfg_pkg::BIT_HF]; // [R12]
  assign CHA_HIGH_INPUT_FREQ_ON_O =
    regs[adc_cfg_pkg::S_CHA_HF][adc_cfg_pkg::BIT_HF]; // [R13]

  // custom word: upper register above lower register
  assign custom_word = {
    regs[adc_cfg_pkg::S_UPPER][adc_cfg_pkg::UP_HI:0], // [R4]
    regs[adc_cfg_pkg::S_LOWER][adc_cfg_pkg::LOW_HI:adc_cfg_pkg::LOW_LO] // [R5]
  }; // [R22]

  adc_channel_out u_cha (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .sample_i(CHA_SAMPLE_I),
    .test_sel_i(regs[adc_cfg_pkg::S_CHA_TEST][adc_cfg_pkg::TEST_HI:0]),
    .custom_i(custom_word),
    .corr_on_i(regs[adc_cfg_pkg::S_DC_LOOP][adc_cfg_pkg::BIT_DC_LOOP_ON]),
    .hold_i(regs[adc_cfg_pkg::S_HOLD][adc_cfg_pkg::BIT_HOLD]),
    .ped_i(regs[adc_cfg_pkg::S_CHA_PED]
      [adc_cfg_pkg::PED_HI:adc_cfg_pkg::PED_LO]),
    .active_i(active),
    .data_o(CHA_DATA_O)
  ); // [R16]

  adc_channel_out u_chb (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .sample_i(CHB_SAMPLE_I),
    .test_sel_i(regs[adc_cfg_pkg::S_CHB_TEST][adc_cfg_pkg::TEST_HI:0]),
    .custom_i(custom_word),
    .corr_on_i(regs[adc_cfg_pkg::S_DC_LOOP][adc_cfg_pkg::BIT_DC_LOOP_ON]),
    .hold_i(regs[adc_cfg_pkg::S_HOLD][adc_cfg_pkg::BIT_HOLD]),
    .ped_i(regs[adc_cfg_pkg::S_CHB_PED]
      [adc_cfg_pkg::PED_HI:adc_cfg_pkg::PED_LO]),
    .active_i(active),
    .data_o(CHB_DATA_O)
  ); // [R16]

  // write of a slot through the bus
  sequence s_bus_write(logic [7:0] idx);
    WRITE_I && ack_reg && BYTEENABLE_I[0] && ADDRESS_I[9:2] == idx;
  endsequence

  property p_soft_reset;
    @(posedge CLK_I) disable iff (!RST_N_I)
    s_bus_write(adc_cfg_pkg::IDX_SOFT_RESET)
      ##0 WRITEDATA_I[adc_cfg_pkg::BIT_SOFT_RESET]
      |=> soft_reset ##1 (regs[adc_cfg_pkg::S_POWER] == 8'h00
        && regs[adc_cfg_pkg::S_CTRL] == 8'h00);
  endproperty
  a_soft_reset: assert property (p_soft_reset) // [R20]
    else $error("soft reset did not clear and self-clear");

  property p_mask;
    @(posedge CLK_I) disable iff (!RST_N_I)
    s_bus_write(adc_cfg_pkg::IDX_CHB_NS_ENABLE) ##0 !soft_reset
      |=> regs[adc_cfg_pkg::S_CHB_NS] == ($past(WRITEDATA_I[7:0]) & 8'h40);
  endproperty
  a_mask: assert property (p_mask) // [R17]
    else $error("reserved bit stored");

  property p_handshake;
    @(posedge CLK_I) disable iff (!RST_N_I)
    ($rose(READ_I) || $rose(WRITE_I)) && !ack_reg
      |-> WAITREQUEST_O ##1 !WAITREQUEST_O ##1 WAITREQUEST_O;
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("bus answer timing broken");

  property p_standby_ready;
    @(posedge CLK_I) disable iff (!RST_N_I)
    STANDBY_ALL_CHANNELS_O |-> !CONVERTER_READY_O;
  endproperty
  a_standby_ready: assert property (p_standby_ready) // [R8]
    else $error("ready during standby");

  property p_pdn_wake;
    @(posedge CLK_I) disable iff (!RST_N_I)
    $fell(FULL_POWER_DOWN_O) && !STANDBY_ALL_CHANNELS_O
      |=> wake_cnt_reg == 14'(PDN_WAKE_CYCLES) && !CONVERTER_READY_O;
  endproperty
  a_pdn_wake: assert property (p_pdn_wake) // [R9]
    else $error("power down wake time not loaded");

  property p_interface;
    @(posedge CLK_I) disable iff (!RST_N_I)
    s_bus_write(adc_cfg_pkg::IDX_OUT_IF_CFG) ##0 !soft_reset
      |=> OUTPUT_PARALLEL_O == ($past(WRITEDATA_I[7:6]) != 2'b00)
        && PARALLEL_CLOCK_DRIVE_O == $past(WRITEDATA_I[5:4]);
  endproperty
  a_interface: assert property (p_interface) // [R6]
    else $error("interface select mismatch");

  property p_filter_mode;
    @(posedge CLK_I) disable iff (!RST_N_I)
    !digital_mode |-> CHB_NOISE_FILTER_INDEX_O == 7'h00;
  endproperty
  a_filter_mode: assert property (p_filter_mode) // [R1]
    else $error("filter index active outside digital mode");

  property p_custom_word;
    @(posedge CLK_I) disable iff (!RST_N_I)
    s_bus_write(adc_cfg_pkg::IDX_TEST_LOWER) ##0 !soft_reset
      |=> custom_word[4:0] == $past(WRITEDATA_I[7:3]);
  endproperty
  a_custom_word: assert property (p_custom_word) // [R5]
    else $error("lower pattern bits misplaced");
endmodule // adc_output_config_regs

// >>> dv/testbench.sv
// self-checking testbench for the output configuration register bank
`timescale 1ns/1ps
module testbench;
  localparam int STANDBY_ALL_CHANNELS_N = 20;
  localparam int PDN_N = 40;
  logic clk;
  logic rst_n;
  logic [9:0] address;
  logic rd_en;
  logic wr_en;
  logic [3:0] byteen;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic waitreq;
  logic [10:0] cha_smp;
  logic [10:0] chb_smp;
  logic [10:0] cha_out;
  logic [10:0] chb_out;
  logic [6:0] filt_idx;
  logic [1:0] pclk_drv;
  logic ns_on;
  logic par_o;
  logic dclk2;
  logic ddata2;
  logic standby_all_channels_o;
  logic pdn_o;
  logic ready_o;
  logic cha_hf;
  logic chb_hf;
  logic [7:0] shadow [adc_cfg_pkg::NUM_SLOTS];
  logic [7:0] r;
  logic [7:0] d;
  logic [7:0] up;
  logic [7:0] lo;
  logic [10:0] pa;
  logic [10:0] pb;
  int n;
  int err_total;
  int checks_done;
  int seed;

  adc_output_config_regs #(.STANDBY_ALL_CHANNELS_WAKE_CYCLES(STANDBY_ALL_CHANNELS_N),
    .PDN_WAKE_CYCLES(PDN_N)) uut (
    .CLK_I(clk), .RST_N_I(rst_n), .ADDRESS_I(address), .READ_I(rd_en),
    .WRITE_I(wr_en), .BYTEENABLE_I(byteen), .WRITEDATA_I(wdata),
    .READDATA_O(rdata), .WAITREQUEST_O(waitreq), .CHA_SAMPLE_I(cha_smp),
    .CHB_SAMPLE_I(chb_smp), .CHA_DATA_O(cha_out), .CHB_DATA_O(chb_out),
    .CHB_NOISE_FILTER_INDEX_O(filt_idx), .CHB_NOISE_SHAPING_ON_O(ns_on),
    .OUTPUT_PARALLEL_O(par_o), .PARALLEL_CLOCK_DRIVE_O(pclk_drv),
    .DIFF_CLOCK_DRIVE_DOUBLE_O(dclk2), .DIFF_DATA_DRIVE_DOUBLE_O(ddata2),
    .STANDBY_ALL_CHANNELS_O(standby_all_channels_o), .FULL_POWER_DOWN_O(pdn_o),
    .CONVERTER_READY_O(ready_o), .CHA_HIGH_INPUT_FREQ_ON_O(cha_hf),
    .CHB_HIGH_INPUT_FREQ_ON_O(chb_hf));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_ctl(input logic [6:0] got, input logic [6:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk);
    address <= {idx, 2'b00};
    wr_en <= wr;
    rd_en <= !wr;
    wdata <= {24'h0, wd};
    @(posedge clk);
    while (waitreq !== 1'b0) begin
      @(posedge clk);
    end
    rd = rdata[7:0];
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [7:0] x;
    bus(1'b1, idx, v, x);
  endtask

  task automatic rdck(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    chk_reg(x, exp);
  endtask

  // midcode plus signed pedestal
  function automatic logic [10:0] ped_exp(input logic [2:0] c);
    int v;
    v = (c[2] && c != 3'b100) ? int'(c) - 8 : int'(c);
    return 11'(int'(adc_cfg_pkg::MIDCODE) + v);
  endfunction

  task automatic wait_ready();
    n = 0;
    while (ready_o !== 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask

  initial begin
    #(8 * 20000);
    err_total++;
    finish_test();
  end

  initial begin
    err_total = 0;
    checks_done = 0;
    seed = 46;
    rst_n = 1'b0;
    address = 10'h000;
    rd_en = 1'b0;
    wr_en = 1'b0;
    byteen = 4'hF;
    wdata = 32'h0;
    cha_smp = adc_cfg_pkg::MIDCODE;
    chb_smp = adc_cfg_pkg::MIDCODE;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < adc_cfg_pkg::NUM_SLOTS; i++) begin
      rdck(adc_cfg_pkg::SLOT_INDEX[i], 8'h00);
    end
    for (int i = 1; i < adc_cfg_pkg::NUM_SLOTS; i++) begin
      d = 8'($random(seed)) & adc_cfg_pkg::SLOT_MASK[i];
      shadow[i] = d;
      wr(adc_cfg_pkg::SLOT_INDEX[i], d);
      rdck(adc_cfg_pkg::SLOT_INDEX[i], d);
    end
    @(negedge clk);
    chk_ctl(7'(ns_on), 7'(shadow[adc_cfg_pkg::S_CHB_NS][6]));
    chk_ctl(7'(dclk2), 7'(shadow[adc_cfg_pkg::S_POWER][6]));
    chk_ctl(7'(ddata2), 7'(shadow[adc_cfg_pkg::S_POWER][5]));
    chk_ctl(7'(chb_hf), 7'(shadow[adc_cfg_pkg::S_CHB_HF][0]));
    chk_ctl(7'(cha_hf), 7'(shadow[adc_cfg_pkg::S_CHA_HF][0]));
    wr(8'h01, 8'hFF);
    rdck(8'h01, 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr(adc_cfg_pkg::IDX_DIG_OPT_ONE, m ? 8'h08 : 8'h00);
      @(negedge clk);
      chk_ctl(filt_idx,
        m ? shadow[adc_cfg_pkg::S_CHB_FILT][6:0] : 7'h00);
    end
    for (int c = 0; c < 4; c++) begin
      wr(adc_cfg_pkg::IDX_OUT_IF_CFG, {2'(c), 2'(3 - c), 4'h0});
      @(negedge clk);
      chk_ctl(7'(par_o), 7'(c != 0));
      chk_ctl(7'(pclk_drv), 7'(3 - c));
    end
    wr(adc_cfg_pkg::IDX_POWER_DRIVE, 8'h00);
    wr(adc_cfg_pkg::IDX_DC_LOOP_CTRL, 8'h00);
    wr(adc_cfg_pkg::IDX_LOOP_HOLD, 8'h00);
    wr(adc_cfg_pkg::IDX_CHA_TEST_SEL, 8'h00);
    wr(adc_cfg_pkg::IDX_CHB_TEST_SEL, 8'h00);
    wait_ready();
    // loop off: raw samples one cycle later
    for (int k = 0; k < 20; k++) begin
      @(posedge clk);
      cha_smp <= 11'($random(seed));
      chb_smp <= 11'($random(seed));
      @(negedge clk);
      if (k > 0) chk_word(cha_out, pa);
      if (k > 0) chk_word(chb_out, pb);
      pa = cha_smp;
      pb = chb_smp;
    end
    up = 8'($random(seed)) & 8'h3F;
    lo = 8'($random(seed)) & 8'hF8;
    wr(adc_cfg_pkg::IDX_TEST_UPPER, up);
    wr(adc_cfg_pkg::IDX_TEST_LOWER, lo);
    wr(adc_cfg_pkg::IDX_CHA_TEST_SEL, 8'h05);
    wr(adc_cfg_pkg::IDX_CHB_TEST_SEL, 8'h05);
    repeat (2) @(negedge clk);
    chk_word(cha_out, {up[5:0], lo[7:3]});
    chk_word(chb_out, {up[5:0], lo[7:3]});
    wr(adc_cfg_pkg::IDX_CHA_TEST_SEL, 8'h02);
    repeat (2) @(negedge clk);
    chk_word(cha_out, adc_cfg_pkg::CODE_MAX);
    chk_word(chb_out, {up[5:0], lo[7:3]});
    wr(adc_cfg_pkg::IDX_CHA_TEST_SEL, 8'h00);
    wr(adc_cfg_pkg::IDX_CHB_TEST_SEL, 8'h00);
    @(posedge clk);
    cha_smp <= adc_cfg_pkg::MIDCODE;
    chb_smp <= adc_cfg_pkg::MIDCODE;
    wr(adc_cfg_pkg::IDX_DC_LOOP_CTRL, 8'h20);
    for (int c = 0; c < 8; c++) begin
      wr(adc_cfg_pkg::IDX_CHA_PEDESTAL, {3'(c), 5'h00});
      wr(adc_cfg_pkg::IDX_CHB_PEDESTAL, {3'(7 - c), 5'h00});
      repeat (3) @(negedge clk);
      chk_word(cha_out, ped_exp(3'(c)));
      chk_word(chb_out, ped_exp(3'(7 - c)));
    end
    // frozen estimate stays at zero while samples leave midcode
    wr(adc_cfg_pkg::IDX_LOOP_HOLD, 8'h80);
    @(posedge clk);
    cha_smp <= adc_cfg_pkg::MIDCODE + 11'h100;
    chb_smp <= adc_cfg_pkg::MIDCODE + 11'h100;
    repeat (10) @(negedge clk);
    chk_word(cha_out, ped_exp(3'h7) + 11'h100);
    chk_word(chb_out, ped_exp(3'h0) + 11'h100);
    for (int m = 0; m < 2; m++) begin
      wr(adc_cfg_pkg::IDX_POWER_DRIVE, m ? 8'h04 : 8'h80);
      @(negedge clk);
      chk_ctl({5'h0, pdn_o, standby_all_channels_o}, m ? 7'h02 : 7'h01);
      chk_ctl(7'(ready_o), 7'h00);
      wr(adc_cfg_pkg::IDX_POWER_DRIVE, 8'h00);
      wait_ready();
      chk_ctl(7'(n >= (m ? PDN_N : STANDBY_ALL_CHANNELS_N) - 2 &&
        n <= (m ? PDN_N : STANDBY_ALL_CHANNELS_N) + 3), 7'h01);
      rdck(adc_cfg_pkg::IDX_STATUS, 8'h01);
    end
    wr(adc_cfg_pkg::IDX_CHA_PEDESTAL, 8'hA0);
    wr(adc_cfg_pkg::IDX_SOFT_RESET, 8'h02);
    rdck(adc_cfg_pkg::IDX_CHA_PEDESTAL, 8'h00);
    rdck(adc_cfg_pkg::IDX_DC_LOOP_CTRL, 8'h00);
    rdck(adc_cfg_pkg::IDX_SOFT_RESET, 8'h00);
    finish_test();
  end
endmodule // testbench
